// >>> src/tcpm_pkg.sv
`default_nettype none
package tcpm_pkg;
   localparam int ADDR_W = 12;
   // =====================================
   // register map
   localparam logic [7:0] OFS_CFG = 8'h00;
   localparam logic [7:0] OFS_MODE_A = 8'h04;
   localparam logic [7:0] OFS_MODE_B = 8'h08;
   localparam logic [7:0] OFS_CTL = 8'h0C;
   localparam logic [7:0] OFS_IMR = 8'h18;
   localparam logic [7:0] OFS_RIS = 8'h1C;
   localparam logic [7:0] OFS_MIS = 8'h20;
   localparam logic [7:0] OFS_ICR = 8'h24;
   localparam logic [7:0] OFS_ILR_A = 8'h28;
   localparam logic [7:0] OFS_ILR_B = 8'h2C;
   localparam logic [7:0] OFS_MAT_A = 8'h30;
   localparam logic [7:0] OFS_MAT_B = 8'h34;
   localparam logic [7:0] OFS_PRE_A = 8'h38;
   localparam logic [7:0] OFS_PRE_B = 8'h3C;
   localparam logic [7:0] OFS_VAL_A = 8'h48;
   localparam logic [7:0] OFS_VAL_B = 8'h4C;
   // =====================================
   // fields and values
   localparam logic [2:0] CFG_32 = 3'h0;
   localparam logic [2:0] CFG_RTC = 3'h1;
   localparam int CFG_16_BIT = 2;
   localparam logic [1:0] MR_ONESHOT = 2'h1;
   localparam logic [1:0] MR_PERIODIC = 2'h2;
   localparam logic [1:0] MR_CAPTURE = 2'h3;
   localparam int CTL_HALF = 8;
   localparam int CTL_RUN = 0;
   localparam int CTL_EVT = 2;
   localparam int CTL_INV = 6;
   localparam logic [31:0] CTL_MASK = 32'h0000_4D4D;
   localparam logic [1:0] EVT_FALL = 2'h1;
   localparam logic [1:0] EVT_BOTH = 2'h3;
   localparam int IRQ_HALF = 8;
   localparam int IRQ_TO = 0;
   localparam int IRQ_CM = 1;
   localparam int IRQ_CE = 2;
   localparam int IRQ_RTC = 3;
   localparam logic [31:0] IRQ_MASK = 32'h0000_070F;
   localparam logic [15:0] CNT_RST = 16'hFFFF;
   localparam logic [15:0] MAT_RST = 16'hFFFF;
   localparam logic [31:0] RTC_FIRST = 32'h0000_0001;
   localparam int RTC_REF_HZ = 32768;
   localparam int RTC_OUT_HZ = 1;
   localparam logic [14:0] RTC_DIV_LAST = 15'(RTC_REF_HZ / RTC_OUT_HZ - 1);
   localparam logic [1:0] RESP_OK = 2'h0;
   localparam logic [1:0] RESP_ERR = 2'h2;

   typedef struct packed {
      logic       ams;
      logic       cmr;
      logic [1:0] mr;
   } tcpm_mode_s;

   typedef enum logic [2:0] {
      HM_OFF    = 3'b000,
      HM_TIMER  = 3'b001,
      HM_ECOUNT = 3'b010,
      HM_ETIME  = 3'b011,
      HM_PWM    = 3'b100
   } tcpm_hmode_e;

   function automatic tcpm_hmode_e half_mode(input tcpm_mode_s m);
      case ({m.ams, m.cmr, m.mr})
         4'h1, 4'h2: half_mode = HM_TIMER;
         4'h3: half_mode = HM_ECOUNT;
         4'h7: half_mode = HM_ETIME;
         4'hA: half_mode = HM_PWM;
         default: half_mode = HM_OFF;
      endcase
   endfunction : half_mode
endpackage : tcpm_pkg
`default_nettype wire

// >>> src/tcpm_timer.sv
`default_nettype none
module tcpm_timer (
   input  wire logic                        CLK_SYS,
   input  wire logic                        SYS_RST,
   input  wire logic                        AWVALID,
   output var  logic                        AWREADY,
   input  wire logic [tcpm_pkg::ADDR_W-1:0] AWADDR,
   input  wire logic [2:0]                  AWPROT,
   input  wire logic                        WVALID,
   output var  logic                        WREADY,
   input  wire logic [31:0]                 WDATA,
   input  wire logic [3:0]                  WSTRB,
   output var  logic                        BVALID,
   input  wire logic                        BREADY,
   output var  logic [1:0]                  BRESP,
   input  wire logic                        ARVALID,
   output var  logic                        ARREADY,
   input  wire logic [tcpm_pkg::ADDR_W-1:0] ARADDR,
   input  wire logic [2:0]                  ARPROT,
   output var  logic                        RVALID,
   input  wire logic                        RREADY,
   output var  logic [31:0]                 RDATA,
   output var  logic [1:0]                  RRESP,
   input  wire logic [1:0]                  CAP_IN,
   output var  logic [1:0]                  CAP_OUT,
   output var  logic [1:0]                  CAP_OE
);
   import tcpm_pkg::*;

   default clocking cb @(posedge CLK_SYS); endclocking
   default disable iff (SYS_RST);

   function automatic logic mapped(input logic [ADDR_W-1:0] a);
      mapped = a[ADDR_W-1:8] == '0 && (a[7:0] == OFS_CFG || a[7:0] == OFS_MODE_A || a[7:0] == OFS_MODE_B
         || a[7:0] == OFS_CTL || (a[7:0] >= OFS_IMR && a[7:0] <= OFS_PRE_B)
         || a[7:0] == OFS_VAL_A || a[7:0] == OFS_VAL_B);
   endfunction : mapped

   // =====================================
   // bus slave
   logic              aw_rdy_q, w_rdy_q, ar_rdy_q, bv_q, rv_q;
   logic [ADDR_W-1:0] wa_q;
   logic [31:0]       wd_q, rd_q, rd_mux, bm;
   logic [3:0]        ws_q;
   logic [1:0]        br_q, rr_q;
   logic              wr_go, hit;
   logic              wr_cfg, wr_ctl, wr_imr, wr_icr, wr_ilr_a, wr_mat_a;
   logic [1:0]        wr_mode, wr_ilr, wr_mat, wr_pre;

   // write takes effect only once both address and data are held
   assign wr_go = !aw_rdy_q && !w_rdy_q && !bv_q;
   assign hit = wr_go && mapped(wa_q);
   assign bm = {{8{ws_q[3]}}, {8{ws_q[2]}}, {8{ws_q[1]}}, {8{ws_q[0]}}};
   assign wr_cfg = hit && wa_q[7:0] == OFS_CFG;
   assign wr_ctl = hit && wa_q[7:0] == OFS_CTL;
   assign wr_imr = hit && wa_q[7:0] == OFS_IMR;
   assign wr_icr = hit && wa_q[7:0] == OFS_ICR;
   assign wr_ilr_a = hit && wa_q[7:0] == OFS_ILR_A;
   assign wr_mat_a = hit && wa_q[7:0] == OFS_MAT_A;
   assign wr_mode = {hit && wa_q[7:0] == OFS_MODE_B, hit && wa_q[7:0] == OFS_MODE_A};
   assign wr_pre = {hit && wa_q[7:0] == OFS_PRE_B, hit && wa_q[7:0] == OFS_PRE_A};

   always_ff @(posedge CLK_SYS) begin
      if (SYS_RST) begin
         aw_rdy_q <= 1'b1;
         w_rdy_q <= 1'b1;
         bv_q <= 1'b0;
         br_q <= RESP_OK;
      end else begin
         if (AWVALID && aw_rdy_q) aw_rdy_q <= 1'b0;
         if (WVALID && w_rdy_q) w_rdy_q <= 1'b0;
         if (wr_go) begin
            bv_q <= 1'b1;
            br_q <= hit ? RESP_OK : RESP_ERR;
         end else if (bv_q && BREADY) begin
            bv_q <= 1'b0;
            aw_rdy_q <= 1'b1;
            w_rdy_q <= 1'b1;
         end
      end
   end

   always_ff @(posedge CLK_SYS) begin
      if (AWVALID && aw_rdy_q) wa_q <= AWADDR;
      if (WVALID && w_rdy_q) begin
         wd_q <= WDATA;
         ws_q <= WSTRB;
      end
   end

   always_ff @(posedge CLK_SYS) begin
      if (SYS_RST) begin
         ar_rdy_q <= 1'b1;
         rv_q <= 1'b0;
         rd_q <= '0;
         rr_q <= RESP_OK;
      end else if (ARVALID && ar_rdy_q) begin
         ar_rdy_q <= 1'b0;
         rv_q <= 1'b1;
         rd_q <= mapped(ARADDR) ? rd_mux : '0;
         rr_q <= mapped(ARADDR) ? RESP_OK : RESP_ERR;
      end else if (rv_q && RREADY) begin
         ar_rdy_q <= 1'b1;
         rv_q <= 1'b0;
      end
   end

   assign AWREADY = aw_rdy_q;
   assign WREADY = w_rdy_q;
   assign BVALID = bv_q;
   assign BRESP = br_q;
   assign ARREADY = ar_rdy_q;
   assign RVALID = rv_q;
   assign RDATA = rd_q;
   assign RRESP = rr_q;

   // =====================================
   // registers
   logic [2:0]  cfg_q;
   tcpm_mode_s  mode_q [2];
   logic [31:0] ctl_q, imr_q, ris_q, ris_set, run_clr, icr_clr;
   logic [15:0] ilr_q [2], mat_q [2], cnt_q [2], cap_q [2], cnt_h [2], val [2], wd_h [2], bm_h [2];
   logic [7:0]  pre_q [2], pcnt_q [2], pcnt_h [2];
   logic        wide, wide_ld, run_a;

   assign wide = !cfg_q[CFG_16_BIT];
   assign run_a = ctl_q[CTL_RUN];
   assign icr_clr = wr_icr ? wd_q & bm & IRQ_MASK : '0;

   always_ff @(posedge CLK_SYS) begin
      if (SYS_RST) begin
         cfg_q <= CFG_32;
         ctl_q <= '0;
         imr_q <= '0;
         ris_q <= '0;
      end else begin
         if (wr_cfg) cfg_q <= (cfg_q & ~bm[2:0]) | (wd_q[2:0] & bm[2:0]);
         // a software write wins over a hardware stop in the same cycle
         ctl_q <= wr_ctl ? ((ctl_q & ~bm) | (wd_q & bm)) & CTL_MASK : ctl_q & ~run_clr;
         if (wr_imr) imr_q <= ((imr_q & ~bm) | (wd_q & bm)) & IRQ_MASK;
         ris_q <= (ris_q & ~icr_clr) | ris_set;
      end
   end

   always_ff @(posedge CLK_SYS) begin
      for (int n = 0; n < 2; n++) begin
         if (SYS_RST) begin
            mode_q[n] <= '0;
            ilr_q[n] <= CNT_RST;
            mat_q[n] <= MAT_RST;
            pre_q[n] <= '0;
         end else begin
            if (wr_mode[n]) mode_q[n] <= (mode_q[n] & ~bm[3:0]) | (wd_q[3:0] & bm[3:0]);
            if (wr_pre[n]) pre_q[n] <= (pre_q[n] & ~bm[7:0]) | (wd_q[7:0] & bm[7:0]);
            if (wr_ilr[n]) ilr_q[n] <= (ilr_q[n] & ~bm_h[n]) | (wd_h[n] & bm_h[n]);
            if (wr_mat[n]) mat_q[n] <= (mat_q[n] & ~bm_h[n]) | (wd_h[n] & bm_h[n]);
         end
      end
   end
   // in the 32-bit modes a word write to the A register fills both halves
   assign wr_ilr = {hit && wa_q[7:0] == OFS_ILR_B || wr_ilr_a && wide, wr_ilr_a};
   assign wr_mat = {hit && wa_q[7:0] == OFS_MAT_B || wr_mat_a && wide, wr_mat_a};
   // only a wide write to A feeds the upper half into B; a direct B write uses the low half
   assign wd_h[0] = wd_q[15:0];
   assign bm_h[0] = bm[15:0];
   assign wd_h[1] = wr_ilr_a || wr_mat_a ? wd_q[31:16] : wd_q[15:0];
   assign bm_h[1] = wr_ilr_a || wr_mat_a ? bm[31:16] : bm[15:0];

   always_comb begin
      case (ARADDR[7:0])
         OFS_CFG: rd_mux = {29'h0, cfg_q};
         OFS_MODE_A: rd_mux = {28'h0, mode_q[0]};
         OFS_MODE_B: rd_mux = {28'h0, mode_q[1]};
         OFS_CTL: rd_mux = ctl_q;
         OFS_IMR: rd_mux = imr_q;
         OFS_RIS: rd_mux = ris_q;
         OFS_MIS: rd_mux = ris_q & imr_q;
         OFS_ILR_A: rd_mux = {wide ? ilr_q[1] : 16'h0, ilr_q[0]};
         OFS_ILR_B: rd_mux = {16'h0, ilr_q[1]};
         OFS_MAT_A: rd_mux = {wide ? mat_q[1] : 16'h0, mat_q[0]};
         OFS_MAT_B: rd_mux = {16'h0, mat_q[1]};
         OFS_PRE_A: rd_mux = {24'h0, pre_q[0]};
         OFS_PRE_B: rd_mux = {24'h0, pre_q[1]};
         OFS_VAL_A: rd_mux = {wide ? cnt_q[1] : 16'h0, val[0]};
         OFS_VAL_B: rd_mux = {16'h0, val[1]};
         default: rd_mux = '0;
      endcase
   end

   // =====================================
   // capture pin sampling
   logic [1:0] s1_q, s2_q, s3_q, ev, stop_h, lvl_h, lvl_q, cap_ev;
   logic [2:0] set_h [2];
   tcpm_hmode_e hmd [2];

   always_ff @(posedge CLK_SYS) begin
      if (SYS_RST) begin
         s1_q <= '0;
         s2_q <= '0;
         s3_q <= '0;
      end else begin
         s1_q <= CAP_IN;
         s2_q <= s1_q;
         s3_q <= s2_q;
      end
   end

   // =====================================
   // 16-bit halves
   for (genvar n = 0; n < 2; n++) begin : g_half
      localparam int C = n * CTL_HALF;
      logic        run, rise, fall, zero, tick;
      logic [15:0] dec;
      logic [1:0]  et;
      assign hmd[n] = wide ? HM_OFF : half_mode(mode_q[n]);
      assign run = ctl_q[C+CTL_RUN];
      assign et = ctl_q[C+CTL_EVT+:2];
      assign rise = s2_q[n] && !s3_q[n];
      assign fall = !s2_q[n] && s3_q[n];
      assign ev[n] = et == EVT_BOTH ? rise || fall : et == EVT_FALL ? fall : rise;
      assign zero = cnt_q[n] == 16'h0000;
      assign tick = pcnt_q[n] == 8'h00;
      assign dec = cnt_q[n] - 16'h0001;
      assign val[n] = hmd[n] == HM_ETIME ? cap_q[n] : cnt_q[n];

      always_comb begin
         cnt_h[n] = cnt_q[n];
         pcnt_h[n] = pcnt_q[n];
         stop_h[n] = 1'b0;
         set_h[n] = 3'h0;
         cap_ev[n] = 1'b0;
         lvl_h[n] = lvl_q[n];
         case (hmd[n])
            HM_TIMER: begin
               if (!run) begin
                  cnt_h[n] = ilr_q[n];
                  pcnt_h[n] = pre_q[n];
               end else if (!tick) begin
                  pcnt_h[n] = pcnt_q[n] - 8'h01;
               end else begin
                  pcnt_h[n] = pre_q[n];
                  cnt_h[n] = zero ? ilr_q[n] : dec;
                  set_h[n][IRQ_TO] = zero;
                  stop_h[n] = zero && mode_q[n].mr == MR_ONESHOT;
               end
            end
            HM_ECOUNT: begin
               if (!run) begin
                  cnt_h[n] = ilr_q[n];
               end else if (ev[n]) begin
                  cnt_h[n] = dec == mat_q[n] ? ilr_q[n] : dec;
                  set_h[n][IRQ_CM] = dec == mat_q[n];
                  stop_h[n] = dec == mat_q[n];
               end
            end
            HM_ETIME: begin
               cnt_h[n] = !run || zero ? ilr_q[n] : dec;
               cap_ev[n] = run && ev[n];
               set_h[n][IRQ_CE] = run && ev[n];
            end
            HM_PWM: begin
               cnt_h[n] = !run || zero ? ilr_q[n] : dec;
               if (!run) lvl_h[n] = 1'b0;
               else if (cnt_q[n] == ilr_q[n]) lvl_h[n] = 1'b1;
               else if (cnt_q[n] == mat_q[n]) lvl_h[n] = 1'b0;
            end
            default: ;
         endcase
      end
   end

   // =====================================
   // 32-bit modes
   logic [31:0] w_cnt, w_ilr, w_mat, w_d;
   logic [14:0] div_q;
   logic        w_to, w_rtc, w_stop, rtc_tick, rtc_on;

   assign w_cnt = {cnt_q[1], cnt_q[0]};
   assign w_ilr = {ilr_q[1], ilr_q[0]};
   assign w_mat = {mat_q[1], mat_q[0]};
   assign rtc_on = cfg_q == CFG_RTC && run_a;
   // the 1 Hz step comes from rising edges of the even pin
   assign rtc_tick = rtc_on && s2_q[0] && !s3_q[0] && div_q == RTC_DIV_LAST;
   assign wide_ld = wide || (wr_cfg && wd_q[2:0] == CFG_RTC);

   always_comb begin
      w_d = w_cnt;
      w_to = 1'b0;
      w_rtc = 1'b0;
      w_stop = 1'b0;
      if (wr_cfg && wd_q[2:0] == CFG_RTC) begin
         w_d = RTC_FIRST;
      end else if (cfg_q == CFG_32) begin
         w_d = !run_a ? w_ilr : w_cnt == '0 ? w_ilr : w_cnt - 32'h1;
         w_to = run_a && w_cnt == '0;
         w_stop = w_to && mode_q[0].mr == MR_ONESHOT;
      end else if (rtc_tick) begin
         w_d = w_cnt == w_mat ? '0 : w_cnt + 32'h1;
         w_rtc = w_cnt == w_mat;
      end
   end

   always_comb begin
      ris_set = '0;
      run_clr = '0;
      ris_set[IRQ_TO] = w_to;
      ris_set[IRQ_RTC] = w_rtc;
      run_clr[CTL_RUN] = w_stop;
      for (int n = 0; n < 2; n++) begin
         ris_set[n*IRQ_HALF+:3] = ris_set[n*IRQ_HALF+:3] | set_h[n];
         run_clr[n*CTL_HALF+CTL_RUN] = run_clr[n*CTL_HALF+CTL_RUN] | stop_h[n];
      end
   end

   always_ff @(posedge CLK_SYS) begin
      if (SYS_RST || !rtc_on) div_q <= '0;
      else if (s2_q[0] && !s3_q[0]) div_q <= div_q == RTC_DIV_LAST ? '0 : div_q + 15'h1;
   end

   always_ff @(posedge CLK_SYS) begin
      for (int n = 0; n < 2; n++) begin
         if (SYS_RST) begin
            cnt_q[n] <= CNT_RST;
            pcnt_q[n] <= '0;
            cap_q[n] <= '0;
            lvl_q[n] <= 1'b0;
            CAP_OUT[n] <= 1'b0;
            CAP_OE[n] <= 1'b0;
         end else begin
            cnt_q[n] <= wide_ld ? w_d[n*16+:16] : cnt_h[n];
            pcnt_q[n] <= pcnt_h[n];
            if (cap_ev[n]) cap_q[n] <= cnt_q[n];
            lvl_q[n] <= lvl_h[n];
            CAP_OUT[n] <= lvl_h[n] ^ ctl_q[n*CTL_HALF+CTL_INV];
            CAP_OE[n] <= hmd[n] == HM_PWM;
         end
      end
   end

   // =====================================
   // checks on both halves and on the 32-bit RTC
   sequence s_ec_hit;
      hmd[0] == HM_ECOUNT && run_a && ev[0] && cnt_q[0] - 16'h1 == mat_q[0] && !wr_go;
   endsequence
   sequence s_ec_done;
      !run_a && ris_q[IRQ_CM] && cnt_q[0] == $past(ilr_q[0]);
   endsequence
   AST_EC_MATCH: assert property (s_ec_hit |=> s_ec_done)
      else $error("edge count match not handled");
   AST_EC_IDLE: assert property (hmd[0] == HM_ECOUNT && !run_a && !wr_go |=> !$rose(ris_q[IRQ_CM]))
      else $error("edge counted while stopped");
   AST_EC_DEC: assert property (hmd[0] == HM_ECOUNT && run_a && ev[0] && cnt_q[0] - 16'h1 != mat_q[0]
      && !wr_go |=> cnt_q[0] == $past(cnt_q[0]) - 16'h1) else $error("edge did not decrement");
   AST_NO_PRESCALE: assert property ((hmd[0] == HM_ETIME || hmd[0] == HM_PWM) && run_a
      && cnt_q[0] != 16'h0 && !wr_go |=> cnt_q[0] == $past(cnt_q[0]) - 16'h1) else $error("count step wrong");
   AST_ET_CAP: assert property (hmd[1] == HM_ETIME && ctl_q[CTL_HALF+CTL_RUN] && ev[1]
      |=> cap_q[1] == $past(cnt_q[1]) && ris_q[IRQ_HALF+IRQ_CE]) else $error("capture missed");
   AST_ET_HOLD: assert property (!cap_ev[1] |=> $stable(cap_q[1]))
      else $error("capture value moved");
   AST_ET_WRAP: assert property (hmd[0] == HM_ETIME && run_a && cnt_q[0] == 16'h0 && !wr_go
      |=> cnt_q[0] == $past(ilr_q[0]) && run_a) else $error("edge time reload wrong");
   AST_PWM_QUIET: assert property (hmd[0] == HM_PWM |=> (ris_q & ~$past(ris_q) & 32'h0000_00FF) == '0)
      else $error("flag raised in pwm mode");
   AST_PWM_OFF: assert property (hmd[0] == HM_PWM && run_a && cnt_q[0] == mat_q[0] && cnt_q[0] != ilr_q[0]
      |=> CAP_OUT[0] == $past(ctl_q[CTL_INV])) else $error("pwm not released at match");
   AST_PWM_ON: assert property (hmd[0] == HM_PWM && run_a && cnt_q[0] == ilr_q[0]
      |=> CAP_OUT[0] != $past(ctl_q[CTL_INV])) else $error("pwm not active at start");
   AST_ONESHOT: assert property (hmd[1] == HM_TIMER && mode_q[1].mr == MR_ONESHOT && ctl_q[CTL_HALF+CTL_RUN]
      && pcnt_q[1] == 8'h0 && cnt_q[1] == 16'h0 && !wr_go |=> !ctl_q[CTL_HALF+CTL_RUN] && ris_q[IRQ_HALF+IRQ_TO])
      else $error("one-shot did not stop");
   AST_ICR: assert property (icr_clr[IRQ_HALF+IRQ_CE] && !ris_set[IRQ_HALF+IRQ_CE] |=> !ris_q[IRQ_HALF+IRQ_CE])
      else $error("flag not cleared");
   AST_RTC: assert property (rtc_tick && w_cnt == w_mat && !wr_go |=> w_cnt == '0 && ris_q[IRQ_RTC])
      else $error("rtc match missed");
endmodule : tcpm_timer
`default_nettype wire

// >>> tb/tcpm_pin_model.sv
`default_nettype none
module tcpm_pin_model (
   input  wire logic       clk_sys,
   input  wire logic [1:0] pwm_pin,
   output var  logic [1:0] cap_pin
);
   timeunit 1ns;
   timeprecision 100ps;
   // =====================================
   // capture source and pwm monitor
   initial cap_pin = 2'b00;
   // a level shorter than two clocks could slip past the synchroniser
   task automatic hold(input int ch, input logic lvl, input int n);
      @(posedge clk_sys);
      cap_pin[ch] <= lvl;
      repeat ((n < 2 ? 2 : n) - 1) @(posedge clk_sys);
   endtask : hold
   task automatic count_high(input int ch, input int n, output int hi);
      hi = 0;
      repeat (n) begin
         @(posedge clk_sys);
         if (pwm_pin[ch] === 1'b1) hi++;
      end
   endtask : count_high
endmodule : tcpm_pin_model
`default_nettype wire

// >>> tb/timer_capture_pwm_modes_test.sv
`default_nettype none
module timer_capture_pwm_modes_test;
   timeunit 1ns;
   timeprecision 100ps;
   import tcpm_pkg::*;
   logic        clk_sys, sys_rst, awvalid, wvalid, bready, arvalid, rready;
   logic        awready, wready, bvalid, arready, rvalid;
   logic [11:0] awaddr, araddr;
   logic [31:0] wdata, rdata, q, v1;
   logic [1:0]  bresp, rresp, lresp, cap_in, cap_out, cap_oe;
   int          failures = 0;
   int          n_compared = 0;
   int          hi;
   tcpm_timer dut (.CLK_SYS(clk_sys), .SYS_RST(sys_rst), .AWVALID(awvalid), .AWREADY(awready),
      .AWADDR(awaddr), .AWPROT(3'h0), .WVALID(wvalid), .WREADY(wready), .WDATA(wdata), .WSTRB(4'hF),
      .BVALID(bvalid), .BREADY(bready), .BRESP(bresp), .ARVALID(arvalid), .ARREADY(arready),
      .ARADDR(araddr), .ARPROT(3'h0), .RVALID(rvalid), .RREADY(rready), .RDATA(rdata), .RRESP(rresp),
      .CAP_IN(cap_in), .CAP_OUT(cap_out), .CAP_OE(cap_oe));
   tcpm_pin_model pm (.clk_sys(clk_sys), .pwm_pin(cap_out), .cap_pin(cap_in));
   initial begin
      clk_sys = 1'b0;
      forever #12.5 clk_sys = ~clk_sys;
   end
   // =====================================
   // checking and bus tasks
   task automatic end_sim();
      $display("compared %0d, mismatches %0d", n_compared, failures);
      if (failures == 0 && n_compared > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask : end_sim
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         failures++;
         $display("ERROR %0t: saw %h, expected %h", $time, seen, exp);
      end
   endtask : chk
   // each transfer lets one edge pass at its end so a following call never re-raises a ready in the same step
   task automatic wr(input logic [7:0] o, input logic [31:0] d);
      awaddr <= {4'h0, o};
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
         @(posedge clk_sys);
         if (awready === 1'b1) awvalid <= 1'b0;
         if (wready === 1'b1) wvalid <= 1'b0;
      end while (bvalid !== 1'b1);
      lresp = bresp;
      bready <= 1'b0;
      @(posedge clk_sys);
   endtask : wr
   task automatic rd(input logic [7:0] o, output logic [31:0] d);
      araddr <= {4'h0, o};
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         @(posedge clk_sys);
         if (arready === 1'b1) arvalid <= 1'b0;
      end while (rvalid !== 1'b1);
      d = rdata;
      lresp = rresp;
      rready <= 1'b0;
      @(posedge clk_sys);
   endtask : rd
   // =====================================
   // scenarios
   task automatic t_reset();
      rd(OFS_ILR_B, q);
      chk(q, 32'h0000_FFFF);
      rd(OFS_MAT_B, q);
      chk(q, {16'h0, MAT_RST});
      rd(8'h10, q);
      chk({q[29:0], lresp}, {30'h0, RESP_ERR});
      wr(8'h40, 32'h1);
      chk({30'h0, lresp}, {30'h0, RESP_ERR});
   endtask : t_reset
   task automatic t_ecount();
      wr(OFS_CTL, 32'h0);
      wr(OFS_CFG, 32'h4);
      wr(OFS_MODE_A, 32'h3);
      wr(OFS_CTL, 32'hC);
      wr(OFS_ILR_A, 32'hA);
      wr(OFS_MAT_A, 32'h6);
      wr(OFS_IMR, 32'h2);
      wr(OFS_CTL, 32'hD);
      for (int i = 0; i < 6; i++) begin
         pm.hold(0, !i[0], 6);
         if (i == 2) begin
            rd(OFS_VAL_A, q);
            chk(q, 32'h7);
            rd(OFS_RIS, q);
            chk(q, 32'h0);
         end
      end
      rd(OFS_RIS, q);
      chk(q, 32'h2);
      rd(OFS_MIS, q);
      chk(q, 32'h2);
      rd(OFS_CTL, q);
      chk(q, 32'hC);
      rd(OFS_VAL_A, q);
      chk(q, 32'hA);
      wr(OFS_ICR, 32'h2);
      rd(OFS_MIS, q);
      chk(q, 32'h0);
   endtask : t_ecount
   task automatic t_etime();
      wr(OFS_CTL, 32'h0);
      wr(OFS_MODE_B, 32'h7);
      // edge-time mode does not use the prescaler, so this value leaves the capture distance below unchanged
      wr(OFS_PRE_B, 32'hFF);
      wr(OFS_IMR, 32'h400);
      wr(OFS_CTL, 32'h100);
      fork
         begin
            pm.hold(1, 1'b1, 4);
            pm.hold(1, 1'b0, 32);
            pm.hold(1, 1'b1, 4);
            pm.hold(1, 1'b0, 4);
         end
         begin
            repeat (12) @(posedge clk_sys);
            rd(OFS_VAL_B, v1);
            rd(OFS_VAL_B, q);
            chk(q, v1);
            rd(OFS_RIS, q);
            chk(q, 32'h400);
         end
      join
      rd(OFS_VAL_B, q);
      chk(v1 - q, 32'd36);
      rd(OFS_MIS, q);
      chk(q, 32'h400);
   endtask : t_etime
   task automatic t_pwm();
      wr(OFS_CTL, 32'h0);
      wr(OFS_ICR, IRQ_MASK);
      wr(OFS_MODE_A, 32'hA);
      wr(OFS_ILR_A, 32'h9);
      wr(OFS_MAT_A, 32'h3);
      wr(OFS_CTL, 32'h1);
      repeat (10) @(posedge clk_sys);
      chk({29'h0, cap_out[1], cap_oe}, 32'h1);
      pm.count_high(0, 100, hi);
      chk(hi, 60);
      wr(OFS_CTL, 32'h41);
      repeat (10) @(posedge clk_sys);
      pm.count_high(0, 100, hi);
      chk(hi, 40);
      rd(OFS_RIS, q);
      chk(q, 32'h0);
   endtask : t_pwm
   task automatic t_oneshot();
      wr(OFS_CTL, 32'h0);
      wr(OFS_MODE_B, {30'h0, MR_ONESHOT});
      wr(OFS_PRE_B, 32'h0);
      wr(OFS_ILR_B, 32'h14);
      wr(OFS_IMR, 32'h100);
      wr(OFS_CTL, 32'h100);
      repeat (40) @(posedge clk_sys);
      rd(OFS_RIS, q);
      chk(q, 32'h100);
      rd(OFS_MIS, q);
      chk(q, 32'h100);
      rd(OFS_CTL, q);
      chk(q, 32'h0);
      wr(OFS_ICR, 32'h100);
      rd(OFS_RIS, q);
      chk(q, 32'h0);
   endtask : t_oneshot
   task automatic t_wide();
      wr(OFS_CTL, 32'h0);
      wr(OFS_CFG, {29'h0, CFG_32});
      wr(OFS_MODE_A, {30'h0, MR_PERIODIC});
      wr(OFS_ILR_A, 32'h5);
      rd(OFS_ILR_B, q);
      chk(q, 32'h0);
      wr(OFS_IMR, 32'h1);
      wr(OFS_CTL, 32'h1);
      repeat (20) @(posedge clk_sys);
      rd(OFS_CTL, q);
      chk(q, 32'h1);
      wr(OFS_CTL, 32'h0);
      rd(OFS_MIS, q);
      chk(q, 32'h1);
      wr(OFS_ICR, 32'h1);
      rd(OFS_RIS, q);
      chk(q, 32'h0);
   endtask : t_wide
   // =====================================
   // main sequence and watchdog
   initial begin
      {sys_rst, awvalid, wvalid, bready, arvalid, rready} = 6'b100000;
      {awaddr, araddr, wdata} = '0;
      repeat (5) @(posedge clk_sys);
      sys_rst <= 1'b0;
      @(posedge clk_sys);
      t_reset();
      t_ecount();
      t_etime();
      t_pwm();
      t_oneshot();
      t_wide();
      end_sim();
   end
   // whole run needs well under two thousand cycles
   initial begin
      repeat (8000) @(posedge clk_sys);
      failures++;
      end_sim();
   end
endmodule : timer_capture_pwm_modes_test
`default_nettype wire
